// *** pkg/lrc_pkg.sv ***
// lrc_pkg: register map, field positions, reset values and carriers
// for the ladder reference control block.
// assumes: single 10 MHz system clock, plain register port.
package lrc_pkg;

	// ----------------------------------------------------------------
	// register map
	// ----------------------------------------------------------------
	localparam logic [1:0] ADDR_CTRL0 = 2'h0;
	localparam logic [1:0] ADDR_CTRL1 = 2'h1;

	// ----------------------------------------------------------------
	// control register 0 field positions
	// ----------------------------------------------------------------
	localparam int BIT_EN   = 7;
	localparam int BIT_LPS  = 6;
	localparam int BIT_OE   = 5;
	localparam int BIT_PSS0 = 2;
	localparam int BIT_PSS1 = 3;
	localparam int BIT_NSS  = 0;

	localparam logic [7:0] CTRL0_MASK  = 8'hed;
	localparam logic [7:0] CTRL1_MASK  = 8'h1f;
	localparam logic [7:0] CTRL0_RESET = 8'h00;
	localparam logic [4:0] LEVEL_RESET = 5'h00;
	localparam logic [4:0] LEVEL_MAX   = 5'h1f;
	localparam logic [4:0] LEVEL_MIN   = 5'h00;

	// ----------------------------------------------------------------
	// source encodings
	// ----------------------------------------------------------------
	localparam logic [1:0] PSS_SUPPLY = 2'h0;
	localparam logic [1:0] PSS_REFPIN = 2'h1;
	localparam logic [1:0] PSS_FIXED  = 2'h2;
	localparam logic [1:0] PSS_RSVD   = 2'h3;

	// ----------------------------------------------------------------
	// carriers
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		LRC_OFF,
		LRC_LADDER,
		LRC_CLAMP_POS,
		LRC_CLAMP_NEG
	} lrc_mode_e;

	typedef struct packed {
		logic       conv_enable;
		logic       low_power_source_sel;
		logic       ref_pin_output_en;
		logic [1:0] pos_source_sel;
		logic       neg_source_sel;
	} lrc_ctrl0_s;

	// analogue switch controls toward the ladder
	typedef struct packed {
		logic       top_connect;
		logic       bottom_connect;
		logic [2:0] pos_src_onehot;
		logic       neg_src_refpin;
		logic [4:0] tap;
		logic       bypass_pos;
		logic       bypass_neg;
	} lrc_analog_s;

endpackage : lrc_pkg

// *** design/lrc_decode.sv ***
// lrc_decode: turns the control fields about to be stored into ladder switch settings.
// assumes: purely combinational, fed from the next control state before it is registered.
`timescale 1ns/1ps
module lrc_decode (
	// control fields
	input  wire lrc_pkg::lrc_ctrl0_s  ctrl,
	input  wire logic [4:0]           level,
	// switch settings
	output lrc_pkg::lrc_analog_s      ana,
	output lrc_pkg::lrc_mode_e        mode
);

	always_comb begin
		ana = '0;
		mode = lrc_pkg::LRC_OFF;
		// source selection is applied whatever the mode
		unique case (ctrl.pos_source_sel)
			lrc_pkg::PSS_SUPPLY: ana.pos_src_onehot = 3'h1;
			lrc_pkg::PSS_REFPIN: ana.pos_src_onehot = 3'h2;
			lrc_pkg::PSS_FIXED:  ana.pos_src_onehot = 3'h4;
			lrc_pkg::PSS_RSVD:   ana.pos_src_onehot = 3'h0;
		endcase
		ana.neg_src_refpin = ctrl.neg_source_sel;
		// one ladder end is opened for low power
		ana.top_connect    = !ctrl.conv_enable ? ctrl.low_power_source_sel : 1'b1;
		ana.bottom_connect = !ctrl.conv_enable ? !ctrl.low_power_source_sel : 1'b1;
		if (ctrl.conv_enable) begin
			mode    = lrc_pkg::LRC_LADDER;
			ana.tap = level;
		end else if (ctrl.low_power_source_sel && level == lrc_pkg::LEVEL_MAX) begin
			mode           = lrc_pkg::LRC_CLAMP_POS;
			ana.bypass_pos = 1'b1;
			ana.tap        = level;
		end else if (!ctrl.low_power_source_sel && level == lrc_pkg::LEVEL_MIN) begin
			mode           = lrc_pkg::LRC_CLAMP_NEG;
			ana.bypass_neg = 1'b1;
		end
		if (ctrl.low_power_source_sel) begin
			ana.bottom_connect = ctrl.conv_enable ? 1'b1 : 1'b0;
		end
	end

endmodule : lrc_decode

// *** design/lrc_top.sv ***
// lrc_top: ladder reference control with two control registers,
// switch decode and pin override.
// assumes: register port strobes are one cycle long and never overlap;
// the pin pad takes output enable active low and an input-detector enable.
//
// Strobed register access and the placing of the registers were decided locally.
`timescale 1ns/1ps

// Operation
// - the enable bit turns the ladder on; cleared keeps it off
// - five-bit level picks one of 32 taps between the two sources
// - ladder ends tie to selected sources so output tracks them
// - disabled, low-power set, level all ones: positive source passes through
// - disabled, low-power clear, level all zeros: negative source passes through
// - disabled, low-power select set opens the negative ladder end
// - disabled, low-power select clear opens the positive ladder end
// - reference reaches the output pin only while pin enable is one
// - pin enable forces digital driver off and input detector off
// - port reads of that pin return zero while it carries the reference
// - positive source: 00 supply, 01 reference pin, 10 fixed_ref buffer 2
// - negative source bit: set picks reference pin, clear picks ground
// - waking from sleep leaves control register 0 unchanged
// - reset disables converter, removes pin output, clears level field
module lrc_top (
	// clock and reset
	input  wire  logic                  clk_sys,
	input  wire  logic                  arst_n,
	// register port
	input  wire  logic [1:0]            reg_addr,
	input  wire  logic [7:0]            reg_wdata,
	input  wire  logic                  reg_wr,
	input  wire  logic                  reg_rd,
	output logic [7:0]                  reg_rdata,
	// power state
	input  wire  logic                  sleep_wake,
	// pin
	input  wire  logic                  pin_digital_in,
	input  wire  logic                  port_drive_en_n,
	output logic                        ref_output_pin_route,
	output logic                        pin_oe_n,
	output logic                        pin_in_detect_en,
	output logic                        pin_read_value,
	// ladder switches
	output lrc_pkg::lrc_analog_s        ana,
	output lrc_pkg::lrc_mode_e          mode
);

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	typedef struct packed {
		lrc_pkg::lrc_ctrl0_s  ctrl0;
		logic [4:0]           level;
		logic [7:0]           rdata;
		logic                 route;
		logic                 oe_n;
		logic                 det_en;
		logic                 pin_rd;
		lrc_pkg::lrc_analog_s ana;
		lrc_pkg::lrc_mode_e   mode;
	} lrc_state_s;

	lrc_state_s           st;
	lrc_state_s           next_st;
	lrc_pkg::lrc_analog_s dec_ana;
	lrc_pkg::lrc_mode_e   dec_mode;
	lrc_pkg::lrc_ctrl0_s  next_ctrl0;
	logic [4:0]           next_level;

	// ----------------------------------------------------------------
	// register writes
	// ----------------------------------------------------------------
	always_comb begin
		next_ctrl0 = st.ctrl0;
		next_level = st.level;
		// sleep_wake is deliberately unused here: wake never touches state
		if (reg_wr && reg_addr == lrc_pkg::ADDR_CTRL0) begin
			next_ctrl0.conv_enable          = reg_wdata[lrc_pkg::BIT_EN];
			next_ctrl0.low_power_source_sel = reg_wdata[lrc_pkg::BIT_LPS];
			next_ctrl0.ref_pin_output_en    = reg_wdata[lrc_pkg::BIT_OE];
			next_ctrl0.pos_source_sel       = {reg_wdata[lrc_pkg::BIT_PSS1],
			                                   reg_wdata[lrc_pkg::BIT_PSS0]};
			next_ctrl0.neg_source_sel       = reg_wdata[lrc_pkg::BIT_NSS];
		end
		if (reg_wr && reg_addr == lrc_pkg::ADDR_CTRL1) begin
			next_level = reg_wdata[4:0];
		end
	end

	// ----------------------------------------------------------------
	// decode of the new settings
	// ----------------------------------------------------------------
	lrc_decode u_decode (
		.ctrl  (next_ctrl0),
		.level (next_level),
		.ana   (dec_ana),
		.mode  (dec_mode)
	);

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb begin
		next_st       = st;
		next_st.ctrl0 = next_ctrl0;
		next_st.level = next_level;
		next_st.ana   = dec_ana;
		next_st.mode  = dec_mode;
		next_st.rdata = 8'h00;
		if (reg_rd) begin
			unique case (reg_addr)
				lrc_pkg::ADDR_CTRL0: begin
					next_st.rdata = {st.ctrl0.conv_enable,
					                 st.ctrl0.low_power_source_sel,
					                 st.ctrl0.ref_pin_output_en,
					                 1'b0,
					                 st.ctrl0.pos_source_sel,
					                 1'b0,
					                 st.ctrl0.neg_source_sel} & lrc_pkg::CTRL0_MASK;
				end
				lrc_pkg::ADDR_CTRL1: begin
					next_st.rdata = {3'h0, st.level} & lrc_pkg::CTRL1_MASK;
				end
				default: begin
					next_st.rdata = 8'h00;
				end
			endcase
		end
		// pin override follows the pin enable
		next_st.route  = next_ctrl0.ref_pin_output_en;
		next_st.oe_n   = next_ctrl0.ref_pin_output_en ? 1'b1 : port_drive_en_n;
		next_st.det_en = !next_ctrl0.ref_pin_output_en;
		next_st.pin_rd = next_ctrl0.ref_pin_output_en ? 1'b0 : pin_digital_in;
	end

	// ----------------------------------------------------------------
	// state register
	// ----------------------------------------------------------------
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			st        <= '0;
			st.oe_n   <= 1'b1;
			st.det_en <= 1'b1;
			st.mode   <= lrc_pkg::LRC_OFF;
		end else begin
			st <= next_st;
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign reg_rdata            = st.rdata;
	assign ref_output_pin_route = st.route;
	assign pin_oe_n             = st.oe_n;
	assign pin_in_detect_en     = st.det_en;
	assign pin_read_value       = st.pin_rd;
	assign ana                  = st.ana;
	assign mode                 = st.mode;

endmodule : lrc_top

// *** testbench/lrc_top_sva.sv ***
// lrc_top_sva: port-level checks of the ladder reference control.
// assumes: bound into lrc_top; write effects land at the taking edge.
`timescale 1ns/1ps
module lrc_top_sva (
	// clock and reset
	input wire logic                 clk_sys,
	input wire logic                 arst_n,
	// register port
	input wire logic [1:0]           reg_addr,
	input wire logic [7:0]           reg_wdata,
	input wire logic                 reg_wr,
	input wire logic                 reg_rd,
	input wire logic [7:0]           reg_rdata,
	// pin and ladder
	input wire logic                 ref_output_pin_route,
	input wire logic                 pin_oe_n,
	input wire logic                 pin_in_detect_en,
	input wire logic                 pin_read_value,
	input wire lrc_pkg::lrc_analog_s ana,
	input wire lrc_pkg::lrc_mode_e   mode
);
	// ----------------------------------------------------------------
	// properties
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!arst_n);
	logic w0;
	assign w0 = reg_wr && reg_addr == 2'h0;
	property p_en; w0 |=> (mode == lrc_pkg::LRC_LADDER) == $past(reg_wdata[7]); endproperty
	a_en: assert property (p_en) else $error("enable bit does not steer ladder");
	property p_tap;
		reg_wr && reg_addr == 2'h1 && mode == lrc_pkg::LRC_LADDER |=> ana.tap == $past(reg_wdata[4:0]);
	endproperty
	a_tap: assert property (p_tap) else $error("tap does not follow level");
	property p_pos; mode == lrc_pkg::LRC_CLAMP_POS |-> ana.bypass_pos && ana.tap == 5'h1f; endproperty
	a_pos: assert property (p_pos) else $error("positive clamp wrong");
	property p_neg; mode == lrc_pkg::LRC_CLAMP_NEG |-> ana.bypass_neg && ana.tap == 5'h00; endproperty
	a_neg: assert property (p_neg) else $error("negative clamp wrong");
	property p_lps;
		w0 && !reg_wdata[7] |=> {ana.top_connect, ana.bottom_connect} == {$past(reg_wdata[6]), !$past(reg_wdata[6])};
	endproperty
	a_lps: assert property (p_lps) else $error("low-power end not opened");
	property p_route; w0 |=> ref_output_pin_route == $past(reg_wdata[5]); endproperty
	a_route: assert property (p_route) else $error("pin route wrong");
	property p_ovr; ref_output_pin_route |-> pin_oe_n && !pin_in_detect_en; endproperty
	a_ovr: assert property (p_ovr) else $error("pin buffers not overridden");
	property p_rz; ref_output_pin_route |-> !pin_read_value; endproperty
	a_rz: assert property (p_rz) else $error("routed pin reads nonzero");
	property p_src;
		w0 |=> ana.pos_src_onehot == (3'h1 << $past(reg_wdata[3:2])) && ana.neg_src_refpin == $past(reg_wdata[0]);
	endproperty
	a_src: assert property (p_src) else $error("source select wrong");
	property p_hold; $past(arst_n) && !reg_wr |=> $stable(ana) && $stable(mode); endproperty
	a_hold: assert property (p_hold) else $error("state changed without write");
	property p_rst;
		disable iff (1'b0) !arst_n |-> !ref_output_pin_route && mode == lrc_pkg::LRC_OFF && ana.tap == 5'h00;
	endproperty
	a_rst: assert property (p_rst) else $error("reset state wrong");
	property p_unused; reg_rd && reg_addr == 2'h0 |=> reg_rdata[4] == 1'b0 && reg_rdata[1] == 1'b0; endproperty
	a_unused: assert property (p_unused) else $error("unused bits read nonzero");
	c_lad: cover property (mode == lrc_pkg::LRC_LADDER);
	c_neg: cover property (mode == lrc_pkg::LRC_CLAMP_NEG);
	c_pos: cover property (mode == lrc_pkg::LRC_CLAMP_POS);
	c_route: cover property (ref_output_pin_route);
endmodule : lrc_top_sva
bind lrc_top lrc_top_sva lrc_top_sva_inst (.clk_sys, .arst_n, .reg_addr, .reg_wdata, .reg_wr,
	.reg_rd, .reg_rdata, .ref_output_pin_route, .pin_oe_n, .pin_in_detect_en, .pin_read_value,
	.ana, .mode);

// *** testbench/lrc_pin_model.sv ***
// lrc_pin_model: pad side of the reference output pin.
// assumes: ext_level is what the board puts on the pin.
`timescale 1ns/1ps
module lrc_pin_model (
	// inputs
	input  wire logic clk_sys,
	input  wire logic ext_level,
	input  wire logic pin_in_detect_en,
	input  wire logic ref_output_pin_route,
	// to the port
	output logic      pin_digital_in
);
	// ----------------------------------------------------------------
	// detector off or analogue on the pad: the level churns
	// ----------------------------------------------------------------
	always @(posedge clk_sys)
		pin_digital_in <= (!pin_in_detect_en || ref_output_pin_route) ? !pin_digital_in : ext_level;
endmodule : lrc_pin_model

// *** testbench/ladder_reference_control_bench.sv ***
// ladder_reference_control_bench: random and corner register traffic with output checks.
// assumes: lrc_top, lrc_pin_model and the bound checker.
`timescale 1ns/1ps
module ladder_reference_control_bench;
	logic clk_sys = 0, arst_n = 1, reg_wr = 0, reg_rd = 0, sleep_wake = 0, port_drive_en_n = 1;
	logic [1:0] reg_addr = 0;
	logic [7:0] reg_wdata = 0, reg_rdata, r0 = 0;
	logic ref_output_pin_route, pin_oe_n, pin_in_detect_en, pin_read_value, pin_digital_in;
	logic ext_level = 0, drv_q, pin_q;
	logic [4:0] lv = 0;
	logic [31:0] seed = 57, v;
	lrc_pkg::lrc_analog_s ana;
	lrc_pkg::lrc_mode_e mode;
	int error_cnt = 0, n_checks = 0, cyc = 0;
	logic [7:0] tc [8] = '{8'h40, 8'h00, 8'h40, 8'h00, 8'h8c, 8'hff, 8'h84, 8'h09};
	logic [4:0] tl [8] = '{5'h1f, 5'h00, 5'h1e, 5'h01, 5'h1f, 5'h00, 5'h0a, 5'h1f};
	lrc_top lrc_top_inst (.clk_sys, .arst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
		.sleep_wake, .pin_digital_in, .port_drive_en_n, .ref_output_pin_route, .pin_oe_n,
		.pin_in_detect_en, .pin_read_value, .ana, .mode);
	lrc_pin_model lrc_pin_model_inst (.clk_sys, .ext_level, .pin_in_detect_en,
		.ref_output_pin_route, .pin_digital_in);
	always #50 clk_sys = !clk_sys;
	always @(posedge clk_sys) begin
		drv_q <= port_drive_en_n;
		pin_q <= pin_digital_in;
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			error_cnt++;
			tally_and_finish();
		end
	end
	// ----------------------------------------------------------------
	// expectations and bus tasks
	// ----------------------------------------------------------------
	function automatic logic [31:0] xs();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction : xs
	function automatic lrc_pkg::lrc_analog_s exp_ana(input logic [7:0] c, input logic [4:0] l);
		lrc_pkg::lrc_analog_s a;
		a = '0;
		a.top_connect = c[7] | c[6];
		a.bottom_connect = c[7] | !c[6];
		a.pos_src_onehot = 3'h1 << c[3:2];
		a.neg_src_refpin = c[0];
		a.bypass_pos = !c[7] && c[6] && l == 5'h1f;
		a.bypass_neg = !c[7] && !c[6] && l == 5'h00;
		a.tap = (c[7] || a.bypass_pos) ? l : 5'h00;
		return a;
	endfunction : exp_ana
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		n_checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("ERROR %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic chk_out();
		lrc_pkg::lrc_analog_s a;
		a = exp_ana(r0, lv);
		chk(ana, a);
		chk(mode, r0[7] ? 2'h1 : a.bypass_pos ? 2'h2 : a.bypass_neg ? 2'h3 : 2'h0);
		chk(ref_output_pin_route, r0[5]);
		chk({pin_oe_n, pin_in_detect_en, pin_read_value}, r0[5] ? 3'h4 : {drv_q, 1'b1, pin_q});
	endtask : chk_out
	task automatic wr(input logic [1:0] a, input logic [7:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
		if (a == 2'h0) r0 = d & lrc_pkg::CTRL0_MASK;
		if (a == 2'h1) lv = d[4:0];
		#1;
		chk_out();
		chk(reg_rdata, 8'h00);
	endtask : wr
	task automatic rd(input logic [1:0] a);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		#1;
		chk(reg_rdata, a == 2'h0 ? r0 : a == 2'h1 ? {3'h0, lv} : 8'h00);
	endtask : rd
	task automatic tally_and_finish();
		if (error_cnt == 0 && n_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : tally_and_finish
	initial begin
		// falling edge after time zero so the asynchronous reset really fires
		arst_n <= 1'b0;
		repeat (16) @(posedge clk_sys);
		arst_n <= 1'b1;
		@(posedge clk_sys);
		#1;
		chk_out();
		for (int i = 0; i < 8; i++) begin
			wr(2'h1, {3'h7, tl[i]});
			wr(2'h0, tc[i]);
			rd(2'h0);
		end
		repeat (150) begin
			v = xs();
			port_drive_en_n <= v[10];
			ext_level <= v[11];
			wr(v[9:8], v[7:0]);
			rd(v[13:12]);
		end
		wr(2'h0, 8'h25);
		sleep_wake <= 1'b1;
		repeat (4) @(posedge clk_sys);
		sleep_wake <= 1'b0;
		#1;
		chk_out();
		wr(2'h1, 8'h1f);
		wr(2'h0, 8'hff);
		arst_n <= 1'b0;
		#50;
		r0 = 8'h00;
		lv = 5'h00;
		chk({ref_output_pin_route, mode, ana.tap}, 8'h00);
		@(posedge clk_sys);
		arst_n <= 1'b1;
		@(posedge clk_sys);
		#1;
		rd(2'h0);
		rd(2'h1);
		tally_and_finish();
	end
endmodule : ladder_reference_control_bench
